// >>> hdl/crd_pkg.sv
// Shared constants and types for the clock request distributor
package crd_pkg;

	// Main source codes
	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_SLOW = 2'h1;
	localparam logic [1:0] SRC_RSVD = 2'h2;
	localparam logic [1:0] SRC_EXT  = 2'h3;

	// Asynchronous clock source codes held by consumers
	localparam logic ASRC_SLOW = 1'h0;
	localparam logic ASRC_EXT  = 1'h1;

	// Prescaler ratio codes
	localparam int          RATIO_COUNT  = 12;
	localparam logic [3:0]  RATIO_RESET  = 4'h7;
	localparam logic [6:0]  RATIO_MAX    = 7'h40;
	localparam logic [1:0]  SRC_RESET    = SRC_FAST;

	// Source level changes needed before a switch completes
	localparam logic [3:0]  SWITCH_EDGES = 4'h8;

	// Divide factor per ratio code
	function automatic logic [6:0] crd_ratio(input logic [3:0] code);
		case (code)
			4'h0:    crd_ratio = 7'h01;
			4'h1:    crd_ratio = 7'h02;
			4'h2:    crd_ratio = 7'h04;
			4'h3:    crd_ratio = 7'h08;
			4'h4:    crd_ratio = 7'h10;
			4'h5:    crd_ratio = 7'h20;
			4'h6:    crd_ratio = 7'h40;
			4'h7:    crd_ratio = 7'h06;
			4'h8:    crd_ratio = 7'h0a;
			4'h9:    crd_ratio = 7'h0c;
			4'ha:    crd_ratio = 7'h18;
			4'hb:    crd_ratio = 7'h30;
			default: crd_ratio = 7'h00;
		endcase
	endfunction : crd_ratio

	typedef enum logic [1:0] {
		SLEEP_ACTIVE,
		SLEEP_IDLE,
		SLEEP_STANDBY,
		SLEEP_POWERDOWN
	} crd_sleep_t;

	typedef struct packed {
		logic fast;
		logic slow;
		logic ext;
	} crd_osc_t;

	typedef struct packed {
		logic rtc;
		logic wdt;
		logic brownout_detector;
	} crd_async_t;

endpackage : crd_pkg

// >>> hdl/crd_prescaler.sv
// Glitch-free divider of the main clock
`timescale 1ns/100ps
`default_nettype none
module crd_prescaler
	import crd_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Main clock edges and ratio
	input  wire logic       run,
	input  wire logic       srcChange,
	input  wire logic [3:0] ratioCode,
	// Divided clock
	output logic            divOut,
	output logic            boundary
);

	logic [6:0] halfCnt_reg;
	logic [6:0] ratioHeld_reg;
	logic       hit;

	assign hit = run && srcChange && (halfCnt_reg == ratioHeld_reg - 7'h01);

	// New ratio only taken at a half-period boundary
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ratioHeld_reg <= crd_ratio(RATIO_RESET);
		end else if (hit && ratioCode < 4'(RATIO_COUNT)) begin
			ratioHeld_reg <= crd_ratio(ratioCode);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			halfCnt_reg <= 7'h00;
			divOut      <= 1'b0;
			boundary    <= 1'b0;
		end else begin
			boundary <= hit;
			if (hit) begin
				halfCnt_reg <= 7'h00;
				divOut      <= ~divOut;
			end else if (run && srcChange) begin
				halfCnt_reg <= halfCnt_reg + 7'h01;
			end
		end
	end

	a_ratio_range: assert property (@(posedge core_clk) disable iff (rst)
		ratioHeld_reg != 7'h00 && ratioHeld_reg <= RATIO_MAX)
		else $error("prescaler ratio out of range");

endmodule : crd_prescaler
`default_nettype wire

// >>> hdl/crd_distributor.sv
// Clock request distributor: source select, prescale, request routing
`timescale 1ns/100ps
`default_nettype none
module crd_distributor
	import crd_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Oscillator and external clock levels
	input  wire crd_osc_t   oscLevel,
	// Main clock control A fields
	input  wire logic [1:0] mainSourceSelect,
	input  wire logic [3:0] prescaleSelect,
	// Power state and main clock requests
	input  wire crd_sleep_t sleepMode,
	input  wire logic       standbyMainRequest,
	input  wire logic       nvmBusy,
	// Consumer configuration
	input  wire logic       rtcEnable,
	input  wire logic       periodicTimerEnable,
	input  wire logic       rtcSource,
	input  wire logic       watchdogEnable,
	input  wire logic       brownoutEnable,
	input  wire logic       brownoutSampled,
	// Oscillator enables
	output crd_osc_t        oscEnable,
	// Derived clocks
	output logic            cpuClock,
	output logic            perClock,
	output logic            peripheralClockPinOut,
	output crd_async_t      asyncRequest,
	output crd_async_t      asyncClock,
	// Status
	output logic            mainRunning,
	output logic [1:0]      activeSource,
	output logic            sourceSwitchingFlag
);

	////////////////////////////////////////////////////////////////////////////
	// Source levels

	logic [1:0] targetSrc_reg;
	logic       pending_reg;
	logic [3:0] edgeCnt_reg;
	logic       activeLevel;
	logic       targetLevel;
	logic       activePrev_reg;
	logic       targetPrev_reg;
	logic       commit;
	logic       divOut;
	logic       boundary;
	logic       mainRun;
	crd_async_t reqNext;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	function automatic logic src_level(input logic [1:0] src, input crd_osc_t lv);
		case (src)
			SRC_FAST: src_level = lv.fast;
			SRC_SLOW: src_level = lv.slow;
			SRC_EXT:  src_level = lv.ext;
			default:  src_level = 1'b0;
		endcase
	endfunction : src_level

	assign activeLevel = src_level(activeSource, oscLevel);
	assign targetLevel = src_level(targetSrc_reg, oscLevel);

	////////////////////////////////////////////////////////////////////////////
	// Main source switching

	// Switch ends only after enough target edges, and at a boundary unless the main clock is stopped
	assign commit = pending_reg && edgeCnt_reg >= SWITCH_EDGES
		&& (boundary || !mainRunning);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			targetSrc_reg <= SRC_RESET;
			pending_reg   <= 1'b0;
		end else if (!pending_reg && mainSourceSelect != SRC_RSVD
				&& mainSourceSelect != activeSource) begin
			targetSrc_reg <= mainSourceSelect;
			pending_reg   <= 1'b1;
		end else if (commit) begin
			pending_reg <= 1'b0;
		end
	end

	// Target edges; a target that stops toggling keeps the switch pending
	always_ff @(posedge core_clk) begin
		if (rst || !pending_reg) begin
			edgeCnt_reg <= 4'h0;
		end else if ((targetLevel ^ targetPrev_reg) && edgeCnt_reg < SWITCH_EDGES) begin
			edgeCnt_reg <= edgeCnt_reg + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			activeSource <= SRC_RESET;
		end else if (commit) begin
			activeSource <= targetSrc_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			activePrev_reg <= 1'b0;
			targetPrev_reg <= 1'b0;
		end else begin
			activePrev_reg <= commit ? targetLevel : activeLevel;
			targetPrev_reg <= targetLevel;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sourceSwitchingFlag <= 1'b0;
		end else begin
			sourceSwitchingFlag <= pending_reg && !commit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main clock run control

	always_comb begin
		case (sleepMode)
			SLEEP_ACTIVE:    mainRun = 1'b1;
			SLEEP_IDLE:      mainRun = 1'b1;
			SLEEP_STANDBY:   mainRun = standbyMainRequest;
			SLEEP_POWERDOWN: mainRun = nvmBusy;
			default:         mainRun = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mainRunning <= 1'b1;
		end else begin
			mainRunning <= mainRun;
		end
	end

	crd_prescaler i_crd_prescaler (
		.core_clk  (core_clk),
		.rst       (rst),
		.run       (mainRunning),
		.srcChange ((activeLevel ^ activePrev_reg) && !commit),
		.ratioCode (prescaleSelect),
		.divOut    (divOut),
		.boundary  (boundary)
	);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpuClock              <= 1'b0;
			perClock              <= 1'b0;
			peripheralClockPinOut <= 1'b0;
		end else begin
			cpuClock              <= divOut;
			perClock              <= divOut;
			peripheralClockPinOut <= divOut;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Asynchronous requests and oscillator enables

	always_comb begin
		reqNext.rtc = rtcEnable || periodicTimerEnable;
		reqNext.wdt = watchdogEnable;
		reqNext.brownout_detector = brownoutEnable && brownoutSampled;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			asyncRequest <= '0;
		end else begin
			asyncRequest <= reqNext;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			asyncClock <= '0;
		end else begin
			asyncClock.rtc <= asyncRequest.rtc
				&& (rtcSource == ASRC_EXT ? oscLevel.ext : oscLevel.slow);
			asyncClock.wdt <= asyncRequest.wdt && oscLevel.slow;
			asyncClock.brownout_detector <= asyncRequest.brownout_detector && oscLevel.slow;
		end
	end

	// An oscillator runs exactly while something asks for it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oscEnable <= '{fast: 1'b1, slow: 1'b0, ext: 1'b0};
		end else begin
			oscEnable.fast <= (mainRun && activeSource == SRC_FAST)
				|| (pending_reg && targetSrc_reg == SRC_FAST);
			oscEnable.slow <= (mainRun && activeSource == SRC_SLOW)
				|| (pending_reg && targetSrc_reg == SRC_SLOW)
				|| reqNext.wdt || reqNext.brownout_detector
				|| (reqNext.rtc && rtcSource == ASRC_SLOW);
			oscEnable.ext  <= (mainRun && activeSource == SRC_EXT)
				|| (pending_reg && targetSrc_reg == SRC_EXT)
				|| (reqNext.rtc && rtcSource == ASRC_EXT);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Watches reset itself, so it must not be disabled by it
	a_reset_source: assert property (disable iff (1'b0) rst |=> activeSource == SRC_FAST
		&& !sourceSwitchingFlag && !pending_reg && mainRunning)
		else $error("reset did not select fast source");

	a_switch_flag: assert property ($rose(pending_reg) |=> sourceSwitchingFlag)
		else $error("switch flag missing during switch");

	a_switch_done: assert property (commit |=> !sourceSwitchingFlag
		&& activeSource == $past(targetSrc_reg))
		else $error("switch did not complete");

	a_select_taken: assert property (!pending_reg && mainSourceSelect != SRC_RSVD
		&& mainSourceSelect != activeSource |=> pending_reg
		&& targetSrc_reg == $past(mainSourceSelect))
		else $error("clock select not taken");

	a_standby_stop: assert property (sleepMode == SLEEP_STANDBY && !standbyMainRequest
		|=> !mainRunning)
		else $error("main clock runs unrequested in standby");

	a_active_run: assert property (sleepMode inside {SLEEP_ACTIVE, SLEEP_IDLE}
		|=> mainRunning)
		else $error("main clock stopped in active or idle");

	a_powerdown_nvm: assert property (sleepMode == SLEEP_POWERDOWN
		|=> mainRunning == $past(nvmBusy))
		else $error("power-down did not wait for memory work");

	a_clock_frozen: assert property (!mainRunning [*2] |=> $stable(perClock))
		else $error("peripheral clock moved while stopped");

	a_cpu_per: assert property (cpuClock == perClock
		&& perClock == peripheralClockPinOut)
		else $error("derived clocks diverge");

	// Requests lag their inputs by one cycle, except just after reset
	a_rtc_request: assert property (!$past(rst) |-> asyncRequest.rtc
		== $past(rtcEnable || periodicTimerEnable))
		else $error("counter clock request wrong");

	a_wdt_request: assert property (!$past(rst) |-> asyncRequest.wdt
		== $past(watchdogEnable) && (oscEnable.slow || !asyncRequest.wdt))
		else $error("watchdog clock request wrong");

	a_bod_request: assert property (!$past(rst) |-> asyncRequest.brownout_detector
		== $past(brownoutEnable && brownoutSampled))
		else $error("brownout clock request wrong");

	a_rtc_route: assert property (reqNext.rtc && rtcSource == ASRC_EXT
		|=> oscEnable.ext)
		else $error("counter request not routed to external clock");

	c_switch_ext: cover property (commit && targetSrc_reg == SRC_EXT);
	c_standby_stop: cover property (sleepMode == SLEEP_STANDBY ##1 !mainRunning);
	c_powerdown_wait: cover property (sleepMode == SLEEP_POWERDOWN && nvmBusy ##1 !nvmBusy);
	c_ratio_boundary: cover property (boundary && prescaleSelect != RATIO_RESET);

endmodule : crd_distributor
`default_nettype wire

// >>> test/crd_osc_model.sv
// Level model of the oscillators and the external clock
`timescale 1ns/100ps
`default_nettype none
module crd_osc_model
	import crd_pkg::*;
(
	// Clock and reset
	input  wire logic     core_clk,
	input  wire logic     rst,
	// Run requests
	input  wire crd_osc_t oscEnable,
	input  wire logic     extRun,
	// Source levels
	output crd_osc_t      oscLevel
);
	// Half periods in core cycles: ext 3, slow 5, fast 2
	localparam int HALF [3] = '{3, 5, 2};
	logic [2:0] cnt [3];
	logic [2:0] lvl;
	logic [2:0] run;

	assign run      = {oscEnable.fast, oscEnable.slow, extRun};
	assign oscLevel = lvl;

	// A stopped source holds its level
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (rst || !run[i]) begin
				cnt[i] <= 3'h0;
				if (rst) begin
					lvl[i] <= 1'b0;
				end
			end else if (cnt[i] == 3'(HALF[i] - 1)) begin
				cnt[i] <= 3'h0;
				lvl[i] <= ~lvl[i];
			end else begin
				cnt[i] <= cnt[i] + 3'h1;
			end
		end
	end
endmodule : crd_osc_model
`default_nettype wire

// >>> test/crd_distributor_tb_top.sv
// Self-checking bench for the clock request distributor
`timescale 1ns/100ps
`default_nettype none
module crd_distributor_tb_top
	import crd_pkg::*;
;
	logic       core_clk, rst, extRun, standbyMainRequest, nvmBusy;
	logic       rtcEnable, periodicTimerEnable, rtcSource;
	logic       watchdogEnable, brownoutEnable, brownoutSampled;
	logic       cpuClock, perClock, peripheralClockPinOut, mainRunning, sourceSwitchingFlag;
	logic       prevClk;
	logic [1:0] mainSourceSelect, activeSource;
	logic [3:0] prescaleSelect;
	logic [4:0] sleepTab [6] = '{5'h10, 5'h14, 5'h08, 5'h1a, 5'h1d, 5'h0c};
	crd_sleep_t sleepMode;
	crd_osc_t   oscLevel, oscEnable;
	crd_async_t asyncRequest, asyncClock, prevAsync;
	int         errors, checked, cycles, runLen, sinceRise, lastPeriod, rises, tog, mark;
	int         ratios [13] = '{1, 2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 48};

	crd_distributor i_crd_distributor (
		.core_clk, .rst, .oscLevel, .mainSourceSelect, .prescaleSelect, .sleepMode,
		.standbyMainRequest, .nvmBusy, .rtcEnable, .periodicTimerEnable, .rtcSource,
		.watchdogEnable, .brownoutEnable, .brownoutSampled, .oscEnable, .cpuClock,
		.perClock, .peripheralClockPinOut, .asyncRequest, .asyncClock, .mainRunning,
		.activeSource, .sourceSwitchingFlag
	);
	crd_osc_model i_crd_osc_model (.core_clk, .rst, .oscEnable, .extRun, .oscLevel);

	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checked++;
		if (seen !== expected) begin
			errors++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, expected);
		end
	endtask : check

	task automatic conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic waitRises(input int k);
		int start;
		start = rises;
		for (int i = 0; i < 3000 && rises < start + k; i++) tick(1);
	endtask : waitRises

	task automatic waitSwitch;
		for (int i = 0; i < 600 && sourceSwitchingFlag !== 1'b0; i++) tick(1);
	endtask : waitSwitch

	// Timeout
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			conclude();
		end
	end

	// Clock monitor on settled values: identical copies, shortest level, period
	always @(negedge core_clk) begin
		check(perClock, cpuClock);
		check(peripheralClockPinOut, cpuClock);
		sinceRise++;
		runLen++;
		if (rst) begin
			runLen = 0;
		end else if (cpuClock !== prevClk) begin
			if (runLen < 2) check(runLen, 2);
			if (cpuClock === 1'b1) begin
				lastPeriod = sinceRise;
				sinceRise = 0;
				rises++;
			end
			runLen = 0;
		end
		prevClk = cpuClock;
		if (asyncClock !== prevAsync) tog++;
		prevAsync = asyncClock;
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		extRun = 1'b0;
		mainSourceSelect = SRC_FAST;
		prescaleSelect = RATIO_RESET;
		sleepMode = SLEEP_ACTIVE;
		{standbyMainRequest, nvmBusy, rtcSource} = 3'h0;
		{rtcEnable, periodicTimerEnable, watchdogEnable, brownoutEnable, brownoutSampled} = 5'h0;
		tick(3);
		check({activeSource, sourceSwitchingFlag, mainRunning, oscEnable}, 7'h0c);
		check(asyncRequest, 3'h0);
		rst = 1'b0;
		waitRises(3);
		check(lastPeriod, 24);
		for (int i = 0; i < 13; i++) begin
			prescaleSelect = 4'(i);
			waitRises(3);
			check(lastPeriod, 4 * ratios[i]);
		end
		prescaleSelect = RATIO_RESET;
		for (int i = 0; i < 32; i++) begin
			{rtcEnable, periodicTimerEnable, watchdogEnable, brownoutEnable, brownoutSampled} = 5'(i);
			tick(3);
			check(asyncRequest, {i[4] | i[3], i[2], i[1] & i[0]});
			check(oscEnable, {1'b1, |i[4:2] | (i[1] & i[0]), 1'b0});
		end
		{rtcEnable, periodicTimerEnable, watchdogEnable, brownoutEnable, brownoutSampled} = 5'h0;
		tick(2);
		// Counter source changed only while the counter is off
		rtcSource = ASRC_EXT;
		rtcEnable = 1'b1;
		tick(2);
		tog = 0;
		tick(40);
		check(tog, 0);
		extRun = 1'b1;
		tick(2);
		tog = 0;
		tick(40);
		check(tog > 0, 1);
		rtcEnable = 1'b0;
		tick(2);
		rtcSource = ASRC_SLOW;
		extRun = 1'b0;
		watchdogEnable = 1'b1;
		tick(2);
		tog = 0;
		tick(40);
		check(tog > 0, 1);
		watchdogEnable = 1'b0;
		for (int i = 0; i < 6; i++) begin
			sleepMode = crd_sleep_t'(sleepTab[i][3:2]);
			{standbyMainRequest, nvmBusy} = sleepTab[i][1:0];
			tick(3);
			check(mainRunning, sleepTab[i][4]);
		end
		mark = rises;
		tick(100);
		check(rises, mark);
		sleepMode = SLEEP_ACTIVE;
		mainSourceSelect = SRC_EXT;
		tick(3);
		check(sourceSwitchingFlag, 1'b1);
		mainSourceSelect = SRC_SLOW;
		tick(100);
		check({activeSource, sourceSwitchingFlag}, {SRC_FAST, 1'b1});
		extRun = 1'b1;
		waitSwitch();
		check(activeSource, SRC_EXT);
		mainSourceSelect = SRC_EXT;
		waitRises(3);
		check(lastPeriod, 36);
		mainSourceSelect = SRC_RSVD;
		tick(5);
		check({activeSource, sourceSwitchingFlag}, {SRC_EXT, 1'b0});
		mainSourceSelect = SRC_SLOW;
		tick(3);
		waitSwitch();
		check({activeSource, oscEnable.slow}, {SRC_SLOW, 1'b1});
		waitRises(3);
		check(lastPeriod, 60);
		mainSourceSelect = SRC_FAST;
		tick(2);
		rst = 1'b1;
		tick(3);
		check({activeSource, sourceSwitchingFlag, mainRunning, oscEnable}, 7'h0c);
		rst = 1'b0;
		waitRises(3);
		check(lastPeriod, 24);
		conclude();
	end
endmodule : crd_distributor_tb_top
`default_nettype wire
